/* File: core/pdmc_power_down.sv */
// power-down mode controller: sleep, software standby and hardware standby.
// assumes reset_n is the chip reset pin, the standby pin is asynchronous,
// and cpu, interrupt, transfer and watchdog signals come from logic on clk.
`timescale 1ns/10ps
module pdmc_power_down
  import pdmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hwStandbyPin_n,
  input  wire logic        sleepExec,
  input  wire logic        irqReq,
  input  wire logic        irqEnable,
  input  wire logic [2:0]  irqLevel,
  input  wire logic [2:0]  cpuMaskLevel,
  input  wire logic        nmiReq,
  input  wire logic        xferService,
  input  wire logic        xferDone,
  input  wire logic        xferCountZero,
  input  wire logic        watchdogEnable,
  input  wire logic [2:0]  watchdogRateSelect,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdData,
  output logic             cpuHalt,
  output logic             clockStop,
  output logic             periphInit,
  output logic             portFloat,
  output logic             oscRun,
  output logic             watchdogClockOnly,
  output logic             irqStart,
  output logic             xferStart,
  output logic             nmiStart,
  output logic             resumeNext,
  output logic [2:0]       powerMode
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    pdmc_mode_e mode;
    logic       standbySelect;
    logic [7:0] wdtCount;
    logic       cpuHalt;
    logic       clockStop;
    logic       periphInit;
    logic       portFloat;
    logic       oscRun;
    logic       wdtClockOnly;
    logic       irqStart;
    logic       xferStart;
    logic       nmiStart;
    logic       resumeNext;
    logic [7:0] rdData;
  } pdmc_state_s;

  localparam pdmc_state_s PDMC_STATE_RST = '{
    mode:          PD_RUN,
    standbySelect: 1'b0,
    wdtCount:      PDMC_WDT_START,
    cpuHalt:       1'b0,
    clockStop:     1'b0,
    periphInit:    1'b0,
    portFloat:     1'b0,
    oscRun:        1'b1,
    wdtClockOnly:  1'b0,
    irqStart:      1'b0,
    xferStart:     1'b0,
    nmiStart:      1'b0,
    resumeNext:    1'b0,
    rdData:        8'h00
  };

  pdmc_state_s st;
  pdmc_state_s next_st;
  logic        pinHigh;
  logic        wdtTick;
  logic        irqAccepted;
  logic        wakeEvent;
  logic        ctrlWrite;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  pdmc_sync #(
    .RST_VAL (1'b1)
  ) u_hw_standby_pin_n_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (hwStandbyPin_n),
    .pinSync (pinHigh)
  );

  pdmc_prescaler u_prescaler (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (st.mode == PD_OSC_WAIT),
    .rateSel (watchdogRateSelect),
    .tick    (wdtTick)
  );

  // a disabled source raises nothing; a low level stays pending
  assign irqAccepted = irqReq && irqEnable && (irqLevel > cpuMaskLevel);
  assign wakeEvent   = irqAccepted || nmiReq;
  assign ctrlWrite   = regWr && (regAddr == PDMC_ADDR_STANDBY_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st            = st;
    next_st.irqStart   = 1'b0;
    next_st.xferStart  = 1'b0;
    next_st.nmiStart   = 1'b0;
    next_st.resumeNext = 1'b0;

    // the select bit refuses to set while the watchdog runs
    if (ctrlWrite) begin
      next_st.standbySelect = regWrData[PDMC_STANDBY_SELECT_BIT_BIT] && !watchdogEnable;
    end

    case (st.mode)
      PD_RUN: begin
        if (sleepExec) begin
          // a watchdog switched on after the bit was set still forces plain sleep
          if (st.standbySelect && !watchdogEnable) begin
            next_st.mode = PD_SW_HW_STANDBY_PIN_N;
          end else begin
            next_st.mode = PD_SLEEP;
          end
        end
      end
      PD_SLEEP: begin
        if (wakeEvent) begin
          if (xferService && !nmiReq) begin
            next_st.mode      = PD_XFER;
            next_st.xferStart = 1'b1;
          end else begin
            next_st.mode     = PD_RUN;
            next_st.irqStart = 1'b1;
          end
        end
      end
      PD_XFER: begin
        if (xferDone) begin
          next_st.mode = PD_RUN;
          // an exhausted count hands the interrupt to the cpu instead
          if (xferCountZero) begin
            next_st.irqStart = 1'b1;
          end else begin
            next_st.resumeNext = 1'b1;
          end
        end
      end
      PD_SW_HW_STANDBY_PIN_N: begin
        if (nmiReq) begin
          next_st.mode     = PD_OSC_WAIT;
          next_st.wdtCount = PDMC_WDT_START;
        end
      end
      PD_OSC_WAIT: begin
        if (wdtTick) begin
          next_st.wdtCount = st.wdtCount + 8'h01;
          if (st.wdtCount == PDMC_WDT_TOP) begin
            next_st.mode          = PD_RUN;
            next_st.nmiStart      = 1'b1;
            next_st.standbySelect = 1'b0;
          end
        end
      end
      PD_HW_HW_STANDBY_PIN_N: begin
        // only the reset pin leaves this mode
        next_st.mode = PD_HW_HW_STANDBY_PIN_N;
      end
      default: begin
        next_st.mode = PD_RUN;
      end
    endcase

    // the standby pin overrides every mode and every pending wake
    if (!pinHigh) begin
      next_st.mode          = PD_HW_HW_STANDBY_PIN_N;
      next_st.standbySelect = 1'b0;
      next_st.irqStart      = 1'b0;
      next_st.xferStart     = 1'b0;
      next_st.nmiStart      = 1'b0;
      next_st.resumeNext    = 1'b0;
    end

    // status outputs follow the next mode so they leave the flops aligned with it
    next_st.cpuHalt      = (next_st.mode != PD_RUN);
    next_st.clockStop    = (next_st.mode == PD_SW_HW_STANDBY_PIN_N) || (next_st.mode == PD_OSC_WAIT)
                           || (next_st.mode == PD_HW_HW_STANDBY_PIN_N);
    next_st.periphInit   = next_st.clockStop;
    next_st.portFloat    = (next_st.mode == PD_HW_HW_STANDBY_PIN_N);
    next_st.oscRun       = (next_st.mode != PD_SW_HW_STANDBY_PIN_N) && (next_st.mode != PD_HW_HW_STANDBY_PIN_N);
    next_st.wdtClockOnly = (next_st.mode == PD_OSC_WAIT);

    next_st.rdData = 8'h00;
    if (regRd) begin
      if (regAddr == PDMC_ADDR_STANDBY_CONTROL) begin
        next_st.rdData = {st.standbySelect, PDMC_RESERVED_ONES};
      end else if (regAddr == PDMC_ADDR_STATUS) begin
        next_st.rdData = {5'h00, st.mode};
      end else begin
        next_st.rdData = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // reset pin forces the reset state from any mode and restarts the oscillator
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= PDMC_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData         = st.rdData;
  assign cpuHalt           = st.cpuHalt;
  assign clockStop         = st.clockStop;
  assign periphInit        = st.periphInit;
  assign portFloat         = st.portFloat;
  assign oscRun            = st.oscRun;
  assign watchdogClockOnly = st.wdtClockOnly;
  assign irqStart          = st.irqStart;
  assign xferStart         = st.xferStart;
  assign nmiStart          = st.nmiStart;
  assign resumeNext        = st.resumeNext;
  assign powerMode         = st.mode;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_sw_standby_nmi;
    st.mode == PD_SW_HW_STANDBY_PIN_N && nmiReq && pinHigh;
  endsequence

  sequence s_count_start;
    st.mode == PD_OSC_WAIT && st.wdtCount == PDMC_WDT_START && st.wdtClockOnly && st.clockStop;
  endsequence

  sequence s_count_overflow;
    st.mode == PD_OSC_WAIT && wdtTick && st.wdtCount == PDMC_WDT_TOP && pinHigh;
  endsequence

  chk_sleep_entry: assert property (
    st.mode == PD_RUN && sleepExec && pinHigh && (!st.standbySelect || watchdogEnable)
    |=> st.mode == PD_SLEEP && st.cpuHalt && !st.clockStop)
    else $error("sleep instruction did not enter sleep mode");

  chk_swstby_entry: assert property (
    st.mode == PD_RUN && sleepExec && pinHigh && st.standbySelect && !watchdogEnable
    |=> st.mode == PD_SW_HW_STANDBY_PIN_N && st.clockStop && st.periphInit && !st.oscRun && !st.portFloat)
    else $error("sleep with standby select did not enter software standby");

  chk_sleep_hold: assert property (
    st.mode == PD_SLEEP && !wakeEvent && pinHigh
    |=> st.mode == PD_SLEEP && st.cpuHalt && !st.clockStop && !st.periphInit && !st.irqStart)
    else $error("sleep mode left without an accepted interrupt");

  chk_irq_wake: assert property (
    st.mode == PD_SLEEP && irqAccepted && !xferService && pinHigh
    |=> st.irqStart && st.mode == PD_RUN ##1 !st.irqStart && !st.cpuHalt)
    else $error("accepted interrupt did not wake the cpu");

  chk_xfer_resume: assert property (
    st.mode == PD_SLEEP && irqAccepted && xferService && !nmiReq && pinHigh
    |=> st.xferStart && st.mode == PD_XFER ##1 st.cpuHalt)
    else $error("transfer wake did not start the transfer controller");

  chk_xfer_done: assert property (
    st.mode == PD_XFER && xferDone && pinHigh
    |=> st.mode == PD_RUN && (st.resumeNext == !$past(xferCountZero)) && (st.irqStart == $past(xferCountZero)))
    else $error("transfer completion resumed the cpu wrongly");

  chk_hw_entry: assert property (
    !pinHigh |=> st.mode == PD_HW_HW_STANDBY_PIN_N && st.portFloat && st.periphInit && !st.standbySelect && !st.oscRun)
    else $error("standby pin low did not enter hardware standby");

  chk_hw_hold: assert property (
    st.mode == PD_HW_HW_STANDBY_PIN_N |=> st.mode == PD_HW_HW_STANDBY_PIN_N)
    else $error("hardware standby left without reset");

  chk_select_lock: assert property (
    ctrlWrite && watchdogEnable && !st.standbySelect |=> !st.standbySelect)
    else $error("standby select set while watchdog enabled");

  chk_reserved_ones: assert property (
    regRd && regAddr == PDMC_ADDR_STANDBY_CONTROL
    |=> regRdData[6:0] == PDMC_RESERVED_ONES && regRdData[7] == $past(st.standbySelect))
    else $error("standby control read back wrong");

  chk_osc_start: assert property (
    s_sw_standby_nmi |=> s_count_start)
    else $error("nmi did not start the stabilisation count from zero");

  chk_overflow_exit: assert property (
    s_count_overflow |=> st.nmiStart && st.mode == PD_RUN && !st.standbySelect && !st.clockStop)
    else $error("count overflow did not resume the chip");

  chk_count_step: assert property (
    st.mode == PD_OSC_WAIT && wdtTick && st.wdtCount != PDMC_WDT_TOP && pinHigh
    |=> st.wdtCount == $past(st.wdtCount) + 8'h01 && st.mode == PD_OSC_WAIT)
    else $error("stabilisation count did not advance on a tick");

  chk_hw_standby_pin_n_hold: assert property (
    st.mode == PD_SW_HW_STANDBY_PIN_N && !nmiReq && pinHigh
    |=> st.mode == PD_SW_HW_STANDBY_PIN_N && st.clockStop && st.cpuHalt && !st.oscRun)
    else $error("software standby left without a wake source");

  // a tick-free cycle must neither advance the count nor release the clock
  chk_wait_hold: assert property (
    st.mode == PD_OSC_WAIT && !wdtTick && pinHigh
    |=> st.mode == PD_OSC_WAIT && st.wdtCount == $past(st.wdtCount) && st.wdtClockOnly)
    else $error("stabilisation wait moved without a tick");

  chk_xfer_hold: assert property (
    st.mode == PD_XFER && !xferDone && pinHigh
    |=> st.mode == PD_XFER && st.cpuHalt && !st.resumeNext && !st.irqStart)
    else $error("transfer wait ended before the transfer finished");

  chk_read_idle: assert property (
    !regRd
    |=> regRdData == 8'h00)
    else $error("read data stood outside its cycle");

  chk_hw_quiet: assert property (
    st.mode == PD_HW_HW_STANDBY_PIN_N
    |=> !st.irqStart && !st.xferStart && !st.nmiStart && !st.resumeNext && st.clockStop && st.portFloat)
    else $error("hardware standby let a start pulse through");

  // nmi in sleep always goes to the cpu, never to the transfer controller
  chk_sleep_nmi: assert property (
    st.mode == PD_SLEEP && nmiReq && pinHigh
    |=> st.irqStart && !st.xferStart && st.mode == PD_RUN)
    else $error("nmi did not wake the cpu from sleep");

endmodule

/* File: common/pdmc_pkg.sv */
// Functional notes
// - sleep instruction with standby select clear enters sleep mode; reset default.
// - sleep instruction with standby select set enters software standby instead.
// - sleep halts the cpu; clock, peripherals, ram and ports keep running or held.
// - an accepted interrupt ends sleep and starts cpu handling or a transfer.
// - after a waking transfer the cpu resumes after sleep unless count reached zero.
// - interrupt at or below the cpu mask level stays pending; sleep continues.
// - a peripheral interrupt disabled by its enable bit never wakes sleep.
// - reset pin low during sleep goes straight to the reset state.
// - standby pin low in sleep or software standby enters hardware standby at once.
// - software standby stops clock, cpu, peripherals; peripherals initialised; cpu, ram, ports kept.
// - watchdog must be stopped first; standby select cannot be set while watchdog enabled.
// - standby select cleared on nmi recovery, on reset and on hardware standby entry.
// - bits 6 to 0 of standby control ignore writes and read as one.
// - nmi in software standby counts watchdog from 00; overflow from ff resumes chip.
// - reset low in software standby starts oscillator; release restarts the whole chip.
// - standby pin low enters hardware standby from anywhere; exit needs pin high then reset.
//
// shared constants of the power-down mode controller.
// assumes an 8-bit register port with 16-bit byte addresses.
package pdmc_pkg;

  localparam logic [15:0] PDMC_ADDR_STANDBY_CONTROL = 16'hff13;
  localparam logic [15:0] PDMC_ADDR_STATUS          = 16'hff14;

  localparam int          PDMC_STANDBY_SELECT_BIT_BIT             = 7;
  localparam logic [7:0]  PDMC_STANDBY_CONTROL_RST  = 8'h7f;
  localparam logic [6:0]  PDMC_RESERVED_ONES        = 7'h7f;

  localparam logic [7:0]  PDMC_WDT_START            = 8'h00;
  localparam logic [7:0]  PDMC_WDT_TOP              = 8'hff;

  localparam int          PDMC_PRESCALE_W           = 12;
  // divide ratio of each watchdog rate, as a power of two
  localparam logic [3:0]  PDMC_RATE_SHIFT [8]       = '{4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc};

  typedef enum logic [2:0] {
    PD_RUN,
    PD_SLEEP,
    PD_SW_HW_STANDBY_PIN_N,
    PD_OSC_WAIT,
    PD_XFER,
    PD_HW_HW_STANDBY_PIN_N
  } pdmc_mode_e;

endpackage

/* File: core/pdmc_sync.sv */
// two-stage synchroniser for asynchronous pin levels.
// assumes the input is a level held far longer than two clock periods.
`timescale 1ns/10ps
module pdmc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      pinSync
);

  logic stage1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1  <= RST_VAL;
      pinSync <= RST_VAL;
    end else begin
      stage1  <= pinIn;
      pinSync <= stage1;
    end
  end

endmodule

/* File: core/pdmc_prescaler.sv */
// watchdog rate prescaler: one-cycle tick at the selected divide ratio.
// assumes run is held only while the stabilisation count is in progress.
`timescale 1ns/10ps
module pdmc_prescaler
  import pdmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic [2:0] rateSel,
  output logic            tick
);

  logic [PDMC_PRESCALE_W-1:0] count;
  logic [PDMC_PRESCALE_W-1:0] mask;

  always_comb begin
    mask = PDMC_PRESCALE_W'((13'h0001 << PDMC_RATE_SHIFT[rateSel]) - 13'h0001);
    tick = run && ((count & mask) == mask);
  end

  // restarts from zero each wait so the first tick is a full period away
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (run) begin
      count <= count + PDMC_PRESCALE_W'(1'b1);
    end else begin
      count <= '0;
    end
  end

endmodule

/* File: tb/pdmc_xfer_model.sv */
// transfer controller stand-in: answers each start with one done pulse.
// assumes start is a one-cycle pulse on clk and delay counts clk cycles.
`timescale 1ns/10ps
module pdmc_xfer_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       xferStart,
  input  wire logic [3:0] delay,
  input  wire logic       zeroCount,
  output logic            xferDone,
  output logic            xferCountZero
);
  logic [4:0] left;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left <= 5'h00;
      xferDone <= 1'b0;
    end else begin
      xferDone <= (left == 5'h01);
      if (xferStart) begin
        left <= {1'b0, delay} + 5'h01;
      end else if (left != 5'h00) begin
        left <= left - 5'h01;
      end
    end
  end

  // the count flag means nothing away from done, so it shows the opposite there
  assign xferCountZero = xferDone ? zeroCount : ~zeroCount;
endmodule

/* File: tb/testbench.sv */
// bench for the power-down mode controller.
// assumes the controller answers one cycle after each taking edge.
`timescale 1ns/10ps
module testbench;
  import pdmc_pkg::*;
  logic        clk, reset_n, hwStandbyPin_n, sleepExec, irqReq, irqEnable;
  logic        nmiReq, xferService, watchdogEnable, regWr, regRd, xZero;
  logic        cpuHalt, clockStop, periphInit, portFloat, oscRun, watchdogClockOnly;
  logic        irqStart, xferStart, nmiStart, resumeNext, xferDone, xferCountZero;
  logic [2:0]  irqLevel, cpuMaskLevel, watchdogRateSelect, powerMode;
  logic [15:0] regAddr;
  logic [7:0]  regWrData, regRdData, d;
  logic [3:0]  xDelay;
  int          failures, checked, n;

  pdmc_power_down uut (.clk, .reset_n, .hwStandbyPin_n, .sleepExec, .irqReq, .irqEnable,
    .irqLevel, .cpuMaskLevel, .nmiReq, .xferService, .xferDone, .xferCountZero,
    .watchdogEnable, .watchdogRateSelect, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .cpuHalt, .clockStop, .periphInit, .portFloat, .oscRun,
    .watchdogClockOnly, .irqStart, .xferStart, .nmiStart, .resumeNext, .powerMode);

  pdmc_xfer_model xfer (.clk, .reset_n, .xferStart, .delay(xDelay), .zeroCount(xZero),
    .xferDone, .xferCountZero);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic sleepNow;
    @(posedge clk);
    sleepExec <= 1'b1;
    @(posedge clk);
    sleepExec <= 1'b0;
    #1;
  endtask

  task automatic nmiNow;
    @(posedge clk);
    nmiReq <= 1'b1;
    @(posedge clk);
    nmiReq <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tRegs;
    rd(PDMC_ADDR_STANDBY_CONTROL, d); chk(d, PDMC_STANDBY_CONTROL_RST);
    wr(PDMC_ADDR_STANDBY_CONTROL, 8'h00);
    rd(PDMC_ADDR_STANDBY_CONTROL, d); chk(d, 8'h7f);
    wr(PDMC_ADDR_STANDBY_CONTROL, 8'hff);
    rd(PDMC_ADDR_STANDBY_CONTROL, d); chk(d, 8'h7f);
    cyc(1); chk(regRdData, 8'h00);
    rd(16'h0000, d); chk(d, 8'h00);
  endtask

  // watchdog still running, so sleep must stay ordinary sleep
  task automatic tSleep;
    sleepNow;
    chk(8'(powerMode), 8'(PD_SLEEP));
    chkb(cpuHalt, 1'b1); chkb(clockStop, 1'b0); chkb(oscRun, 1'b1);
    rd(PDMC_ADDR_STATUS, d); chk(d, 8'(PD_SLEEP));
    @(posedge clk);
    irqLevel <= 3'h2;
    irqReq <= 1'b1;
    cyc(4); chk(8'(powerMode), 8'(PD_SLEEP));
    @(posedge clk);
    irqLevel <= 3'h3;
    irqEnable <= 1'b0;
    cyc(4); chk(8'(powerMode), 8'(PD_SLEEP));
    @(posedge clk);
    irqEnable <= 1'b1;
    cyc(1); chkb(irqStart, 1'b1); chk(8'(powerMode), 8'(PD_RUN));
    @(posedge clk);
    irqReq <= 1'b0;
    cyc(1); chkb(irqStart, 1'b0);
    sleepNow;
    nmiNow; chkb(irqStart, 1'b1); chk(8'(powerMode), 8'(PD_RUN));
  endtask

  task automatic tXfer(input logic z);
    xZero = z;
    sleepNow;
    @(posedge clk);
    xferService <= 1'b1;
    irqReq <= 1'b1;
    cyc(1); chkb(xferStart, 1'b1); chk(8'(powerMode), 8'(PD_XFER));
    @(posedge clk);
    irqReq <= 1'b0;
    xferService <= 1'b0;
    for (n = 0; n < 20 && (resumeNext | irqStart) !== 1'b1; n++) cyc(1);
    chkb(resumeNext, !z); chkb(irqStart, z); chk(8'(powerMode), 8'(PD_RUN));
  endtask

  task automatic tSwStby;
    @(posedge clk);
    watchdogEnable <= 1'b0;
    watchdogRateSelect <= 3'h0;
    wr(PDMC_ADDR_STANDBY_CONTROL, 8'h80);
    rd(PDMC_ADDR_STANDBY_CONTROL, d); chk(d, 8'hff);
    sleepNow;
    chk(8'(powerMode), 8'(PD_SW_HW_STANDBY_PIN_N));
    chkb(clockStop, 1'b1); chkb(periphInit, 1'b1); chkb(oscRun, 1'b0); chkb(cpuHalt, 1'b1);
    nmiNow;
    chk(8'(powerMode), 8'(PD_OSC_WAIT)); chkb(watchdogClockOnly, 1'b1); chkb(oscRun, 1'b1);
    for (n = 0; n < 700 && nmiStart !== 1'b1; n++) cyc(1);
    // 256 ticks of two cycles each, give or take the prescaler phase
    chkb(n >= 508 && n <= 516, 1'b1); chk(8'(powerMode), 8'(PD_RUN));
    chkb(nmiStart, 1'b1); chkb(clockStop, 1'b0); chkb(watchdogClockOnly, 1'b0);
    rd(PDMC_ADDR_STANDBY_CONTROL, d); chk(d, 8'h7f);
  endtask

  task automatic tResetIn(input logic sel);
    wr(PDMC_ADDR_STANDBY_CONTROL, sel ? 8'h80 : 8'h00);
    sleepNow;
    chk(8'(powerMode), sel ? 8'(PD_SW_HW_STANDBY_PIN_N) : 8'(PD_SLEEP));
    @(posedge clk);
    reset_n <= 1'b0;
    cyc(1); chkb(oscRun, 1'b1); chk(8'(powerMode), 8'(PD_RUN));
    cyc(4);
    @(posedge clk);
    reset_n <= 1'b1;
    cyc(2); chkb(clockStop, 1'b0); chkb(cpuHalt, 1'b0);
  endtask

  // select set first, then the watchdog switched on: sleep stays ordinary sleep
  task automatic tHwStby;
    wr(PDMC_ADDR_STANDBY_CONTROL, 8'h80);
    @(posedge clk);
    watchdogEnable <= 1'b1;
    sleepNow;
    chk(8'(powerMode), 8'(PD_SLEEP));
    @(posedge clk);
    hwStandbyPin_n <= 1'b0;
    cyc(4); chk(8'(powerMode), 8'(PD_HW_HW_STANDBY_PIN_N)); chkb(portFloat, 1'b1);
    rd(PDMC_ADDR_STANDBY_CONTROL, d); chk(d, 8'h7f);
    @(posedge clk);
    hwStandbyPin_n <= 1'b1;
    nmiNow;
    cyc(4); chk(8'(powerMode), 8'(PD_HW_HW_STANDBY_PIN_N));
    @(posedge clk);
    reset_n <= 1'b0;
    cyc(4);
    @(posedge clk);
    reset_n <= 1'b1;
    cyc(2); chk(8'(powerMode), 8'(PD_RUN)); chkb(portFloat, 1'b0);
    rd(PDMC_ADDR_STANDBY_CONTROL, d); chk(d, 8'h7f);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // the whole run needs about 650 cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize;
  end

  initial begin
    {reset_n, sleepExec, irqReq, nmiReq, xferService, regWr, regRd, xZero} = '0;
    {hwStandbyPin_n, irqEnable, watchdogEnable} = 3'h7;
    irqLevel = 3'h3;
    cpuMaskLevel = 3'h2;
    watchdogRateSelect = 3'h0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    xDelay = 4'h3;
    failures = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    tRegs;
    tSleep;
    tXfer(1'b0);
    tXfer(1'b1);
    tSwStby;
    tResetIn(1'b0);
    tResetIn(1'b1);
    tHwStby;
    summarize;
  end
endmodule
